// [hdl/ucg_core.sv]
// serial transceiver: clock generation, transmitter and receiver
// assumes all inputs synchronous to clk_in except the transfer clock pin
//
// Contract
// - sync_mode_select 0 selects asynchronous, 1 selects synchronous operation.
// - in sync mode, pin direction output means master, input means slave.
// - transfer clock pin used only in synchronous mode.
// - baud counter on system clock, reloads at zero or low-byte write.
// - one baud tick per zero, rate fosc over divisor plus one.
// - transmitter divides baud ticks by 16, 8 or 2 per mode; sync slave follows the external clock.
// - receiver uses 16 or 8 states per bit in async; sync samples once per bit on the sample edge.
// - baud divisor is 12 bits from high and low bytes.
// - double speed affects only asynchronous operation.
// - double speed receiver takes 8 samples per bit, not 16.
// - slave clock passes a sync register then edge detector, two-cycle delay.
// - single transmit buffer ahead of shift register, no gaps between frames.
// - two-entry receive buffer, flags frame, overrun and parity errors.
// - frames carry 5 to 9 data bits and one or two stops.
// - odd or even parity generated on transmit, checked on receive.
// - asynchronous receiver low-pass filters input and rejects false start bits.
// - three events: transmit complete, buffer empty, receive complete.
// - clock and data recovery only in asynchronous reception.
// - polarity 0 changes data on rising, samples on falling; 1 swapped.
// - start bit, data lsb first, optional parity, stops; idle high.
// - parity is xor of data bits, inverted for odd.
`timescale 1ns/1ps
`default_nettype none
`include "ucg_defs.svh"
module ucg_core (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   // configuration
   input wire ucg_pkg::ucg_cfg_t cfg_in,
   input wire logic serial_power_reduction_bit_in,
   input wire logic [7:0] baud_divisor_low_in,
   input wire logic baud_divisor_low_wr_in,
   input wire logic [3:0] baud_divisor_high_in,
   input wire logic baud_divisor_high_wr_in,
   // transmit data
   input wire logic [8:0] tx_data_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   // receive data
   output logic rx_valid_out,
   input wire logic rx_ready_in,
   output ucg_pkg::ucg_rx_word_t rx_word_out,
   // events
   output logic tx_complete_out,
   output logic tx_buffer_empty_out,
   output logic rx_complete_out,
   // pins
   output logic serial_tx_pin_out,
   input wire logic serial_rx_pin_in,
   input wire logic transfer_clock_pin_in,
   output logic transfer_clock_pin_out,
   output logic transfer_clock_pin_oe_out
);
   import ucg_pkg::*;

   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   function automatic ucg_mode_t decode_mode(input ucg_cfg_t c);
      if (!c.sync_mode_select) begin
         decode_mode = c.double_speed_bit ? UCG_ASYNC_DOUBLE : UCG_ASYNC_NORMAL;
      end else begin
         decode_mode = c.transfer_clock_pin_direction ? UCG_SYNC_MASTER : UCG_SYNC_SLAVE;
      end
   endfunction : decode_mode

   function automatic logic [4:0] ticks_per_bit(input ucg_mode_t m);
      unique case (m)
         UCG_ASYNC_NORMAL: ticks_per_bit = `UCG_OS_NORMAL;
         UCG_ASYNC_DOUBLE: ticks_per_bit = `UCG_OS_DOUBLE;
         UCG_SYNC_MASTER: ticks_per_bit = `UCG_OS_SYNC;
         default: ticks_per_bit = `UCG_OS_SYNC;
      endcase
   endfunction : ticks_per_bit

   ucg_mode_t mode;
   logic active;
   logic is_sync;
   logic is_slave;
   assign mode = decode_mode(cfg_in);
   assign is_sync = cfg_in.sync_mode_select;
   assign is_slave = (mode == UCG_SYNC_SLAVE);
   assign active = !serial_power_reduction_bit_in;

   // ----------------------------------------
   // baud generator
   // ----------------------------------------
   logic [3:0] div_high;
   logic [7:0] div_low;
   logic [`UCG_DIV_W-1:0] baud_cnt;
   logic baud_tick;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         div_high <= 4'h0;
         div_low <= 8'h00;
      end else if (ce_in) begin
         if (baud_divisor_high_wr_in) begin
            div_high <= baud_divisor_high_in;
         end
         if (baud_divisor_low_wr_in) begin
            div_low <= baud_divisor_low_in;
         end
      end
   end
   assign baud_tick = active && (baud_cnt == 12'h000);
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         baud_cnt <= `UCG_DIV_RESET;
      end else if (ce_in) begin
         if (baud_divisor_low_wr_in) begin
            baud_cnt <= {div_high, baud_divisor_low_in};
         end else if (baud_cnt == 12'h000) begin
            baud_cnt <= {div_high, div_low};
         end else begin
            baud_cnt <= baud_cnt - 12'h001;
         end
      end
   end

   // ----------------------------------------
   // external clock sync and edges
   // ----------------------------------------
   logic xck_meta;
   logic xck_sync;
   logic xck_prev;
   logic xck_rise;
   logic xck_fall;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         xck_meta <= 1'b0;
         xck_sync <= 1'b0;
         xck_prev <= 1'b0;
      end else if (ce_in) begin
         xck_meta <= transfer_clock_pin_in;
         xck_sync <= xck_meta;
         xck_prev <= xck_sync;
      end
   end
   assign xck_rise = is_slave && xck_sync && !xck_prev;
   assign xck_fall = is_slave && !xck_sync && xck_prev;

   // ----------------------------------------
   // master clock out and bit strobes
   // ----------------------------------------
   logic xcko;
   logic change_edge;
   logic sample_edge;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         xcko <= 1'b0;
      end else if (ce_in) begin
         if (mode != UCG_SYNC_MASTER) begin
            xcko <= 1'b0;
         end else if (baud_tick) begin
            xcko <= ~xcko;
         end
      end
   end
   assign transfer_clock_pin_out = xcko ^ cfg_in.clock_polarity_select;
   assign transfer_clock_pin_oe_out = (mode == UCG_SYNC_MASTER);
   // change on rising (pol 0) or falling (pol 1) of the pin level
   always_comb begin
      change_edge = 1'b0;
      sample_edge = 1'b0;
      if (mode == UCG_SYNC_MASTER) begin
         change_edge = baud_tick && !xcko;
         sample_edge = baud_tick && xcko;
      end else if (is_slave) begin
         change_edge = cfg_in.clock_polarity_select ? xck_fall : xck_rise;
         sample_edge = cfg_in.clock_polarity_select ? xck_rise : xck_fall;
      end
   end

   // ----------------------------------------
   // transmitter
   // ----------------------------------------
   logic [8:0] tx_buf;
   logic tx_buf_full;
   logic [11:0] tx_shift;
   logic [3:0] tx_bits_left;
   logic [4:0] tx_tick_cnt;
   logic tx_bit_end;
   logic tx_load;
   logic [3:0] nbits;
   logic [8:0] tx_mask;
   logic [8:0] tx_d;
   logic tx_par;
   assign nbits = (cfg_in.char_size == 3'h7) ? 4'h9 : {2'b00, cfg_in.char_size[1:0]} + 4'h5;
   assign tx_mask = 9'h1FF >> (4'h9 - nbits);
   assign tx_d = tx_buf & tx_mask;
   assign tx_par = (^tx_d) ^ cfg_in.parity_odd;
   assign tx_ready_out = active && !tx_buf_full;
   assign tx_buffer_empty_out = !tx_buf_full;
   always_comb begin
      if (is_sync) begin
         tx_bit_end = change_edge;
      end else begin
         tx_bit_end = baud_tick && (tx_tick_cnt == ticks_per_bit(mode) - 5'h01);
      end
   end
   // next frame may load at the end of the last stop bit, so frames run gapless
   assign tx_load = tx_buf_full && (is_sync ? change_edge : baud_tick)
      && (tx_bits_left == 4'h0 || (tx_bits_left == 4'h1 && tx_bit_end));
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_buf <= 9'h000;
         tx_buf_full <= 1'b0;
      end else if (ce_in) begin
         if (tx_valid_in && tx_ready_out) begin
            tx_buf <= tx_data_in;
            tx_buf_full <= 1'b1;
         end else if (tx_load) begin
            tx_buf_full <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_tick_cnt <= 5'h00;
      end else if (ce_in) begin
         if (tx_load || tx_bit_end || tx_bits_left == 4'h0) begin
            tx_tick_cnt <= 5'h00;
         end else if (baud_tick) begin
            tx_tick_cnt <= tx_tick_cnt + 5'h01;
         end
      end
   end
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_shift <= 12'hFFF;
         tx_bits_left <= 4'h0;
         serial_tx_pin_out <= 1'b1;
         tx_complete_out <= 1'b0;
      end else if (ce_in) begin
         tx_complete_out <= 1'b0;
         if (tx_load) begin
            // frame: start, data lsb first, parity, stops
            tx_shift <= ({3'h7, tx_d} | ~{3'h0, tx_mask}) & ~(12'h001 << nbits)
               | ({11'h000, tx_par | !cfg_in.parity_en} << nbits) | ~(12'hFFF >> 1);
            // one bit end per sent bit, the last one returns the line to idle
            tx_bits_left <= nbits + {3'h0, cfg_in.parity_en} + {3'h0, cfg_in.two_stop} + 4'h2;
            serial_tx_pin_out <= 1'b0;
         end else if (tx_bits_left != 4'h0 && tx_bit_end) begin
            serial_tx_pin_out <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[11:1]};
            tx_bits_left <= tx_bits_left - 4'h1;
            if (tx_bits_left == 4'h1) begin
               serial_tx_pin_out <= 1'b1;
               tx_complete_out <= !tx_buf_full;
            end
         end
      end
   end

   // ----------------------------------------
   // receiver: filter, recovery, shift
   // ----------------------------------------
   logic [2:0] rx_hist;
   logic rx_filt;
   logic [4:0] rx_tick_cnt;
   logic [3:0] rx_bit_idx;
   logic [8:0] rx_data;
   logic rx_busy;
   logic rx_take;
   logic [4:0] half_bit;
   ucg_rx_word_t rx_new;
   logic rx_push;
   logic rx_buf_ready;
   logic overrun_pend;
   assign half_bit = cfg_in.double_speed_bit ? `UCG_HALF_DOUBLE : `UCG_HALF_NORMAL;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_hist <= 3'h7;
      end else if (ce_in && (is_sync ? sample_edge : baud_tick)) begin
         rx_hist <= {rx_hist[1:0], serial_rx_pin_in};
      end
   end
   // majority of three samples in async, latest sample alone in sync
   assign rx_filt = is_sync ? rx_hist[0] : ({1'b0, rx_hist[0]} + {1'b0, rx_hist[1]}
      + {1'b0, rx_hist[2]} >= `UCG_FILT_VOTE);
   // take point: mid-bit in async, sample edge in sync
   assign rx_take = is_sync ? (rx_busy && sample_edge)
      : (rx_busy && baud_tick && rx_tick_cnt == ticks_per_bit(mode) - 5'h01);
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_busy <= 1'b0;
         rx_tick_cnt <= 5'h00;
         rx_bit_idx <= 4'h0;
         rx_data <= 9'h000;
         rx_push <= 1'b0;
         rx_new <= '0;
      end else if (ce_in) begin
         rx_push <= 1'b0;
         if (!rx_busy) begin
            if (is_sync && sample_edge && !serial_rx_pin_in) begin
               rx_busy <= 1'b1;
               rx_bit_idx <= 4'h1;
               rx_data <= 9'h000;
            end else if (!is_sync && baud_tick && !rx_filt) begin
               rx_busy <= 1'b1;
               rx_tick_cnt <= 5'h01;
               rx_bit_idx <= 4'h0;
               rx_data <= 9'h000;
            end
         end else begin
            if (baud_tick && !is_sync) begin
               rx_tick_cnt <= rx_take ? 5'h00 : rx_tick_cnt + 5'h01;
               // false start: line high again at centre of start bit
               if (rx_bit_idx == 4'h0 && rx_tick_cnt == half_bit && rx_filt) begin
                  rx_busy <= 1'b0;
               end else if (rx_bit_idx == 4'h0 && rx_tick_cnt == half_bit) begin
                  rx_tick_cnt <= 5'h01;
                  rx_bit_idx <= 4'h1;
               end
            end
            if (rx_take && rx_bit_idx != 4'h0) begin
               rx_bit_idx <= rx_bit_idx + 4'h1;
               if (rx_bit_idx <= nbits) begin
                  rx_data[rx_bit_idx - 4'h1] <= rx_filt;
               end else if (cfg_in.parity_en && rx_bit_idx == nbits + 4'h1) begin
                  rx_new.parity_err <= rx_filt ^ (^rx_data) ^ cfg_in.parity_odd;
               end else begin
                  // only the first stop bit is checked
                  rx_busy <= 1'b0;
                  rx_push <= 1'b1;
                  rx_new.data <= rx_data;
                  rx_new.frame_err <= !rx_filt;
                  // flags that a word was lost before this one
                  rx_new.overrun <= overrun_pend;
                  if (!cfg_in.parity_en) begin
                     rx_new.parity_err <= 1'b0;
                  end
               end
            end
         end
      end
   end
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         overrun_pend <= 1'b0;
      end else if (ce_in) begin
         if (rx_push && !rx_buf_ready) begin
            overrun_pend <= 1'b1;
         end else if (rx_push) begin
            overrun_pend <= 1'b0;
         end
      end
   end

   ucg_rx_buf u_rx_buf (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .ce_in(ce_in),
      .in_valid_in(rx_push),
      .in_ready_out(rx_buf_ready),
      .in_word_in(rx_new),
      .out_valid_out(rx_valid_out),
      .out_ready_in(rx_ready_in),
      .out_word_out(rx_word_out)
   );
   assign rx_complete_out = rx_valid_out;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_baud_reload: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && baud_divisor_low_wr_in |=> baud_cnt == {div_high, div_low}) else $error("baud reload missed");
   a_baud_count: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && baud_cnt != 12'h000 && !baud_divisor_low_wr_in |=> baud_cnt == $past(baud_cnt) - 12'h001)
      else $error("baud count step wrong");
   a_pin_async_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !cfg_in.sync_mode_select |-> !transfer_clock_pin_oe_out) else $error("clock pin driven in async");
   a_master_drive: assert property (@(posedge clk_in) disable iff (!resetn_in)
      cfg_in.sync_mode_select && cfg_in.transfer_clock_pin_direction |-> transfer_clock_pin_oe_out)
      else $error("master not driving clock");
   a_slave_edge: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in [*3] ##0 is_slave && $rose(xck_sync) |-> xck_rise) else $error("slave edge lost");
   a_idle_high: assert property (@(posedge clk_in) disable iff (!resetn_in)
      tx_bits_left == 4'h0 && !tx_load |=> serial_tx_pin_out) else $error("idle line not high");
   a_start_low: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && tx_load |=> !serial_tx_pin_out) else $error("start bit not low");
   a_tx_ratio: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !is_sync |-> tx_tick_cnt < ticks_per_bit(mode))
      else $error("tx bit length wrong");
   a_ds_sync_none: assert property (@(posedge clk_in) disable iff (!resetn_in)
      is_sync |-> ticks_per_bit(mode) == `UCG_OS_SYNC) else $error("double speed leaked into sync");
   c_tx_frame: cover property (@(posedge clk_in) tx_complete_out);
   c_rx_frame: cover property (@(posedge clk_in) rx_push && !rx_new.frame_err);
   c_overrun: cover property (@(posedge clk_in) rx_push && !rx_buf_ready);
   c_slave_edge: cover property (@(posedge clk_in) xck_rise);
endmodule : ucg_core
`default_nettype wire

// [hdl/ucg_defs.svh]
// timing, field and mode constants for the serial clock generator and frame engine
// included by the core and receive buffer modules, not by the package
`ifndef UCG_DEFS_SVH
`define UCG_DEFS_SVH
`define UCG_DIV_W 12
`define UCG_DIV_RESET 12'h000
`define UCG_OS_NORMAL 5'h10
`define UCG_OS_DOUBLE 5'h08
`define UCG_OS_SYNC 5'h02
`define UCG_HALF_NORMAL 5'h08
`define UCG_HALF_DOUBLE 5'h04
`define UCG_FILT_VOTE 2'h2
`define UCG_BUF_DEPTH 2
`endif

// [hdl/ucg_pkg.sv]
// types shared by the serial clock generator and its receive buffer
// assumes ucg_defs.svh is on the include path
package ucg_pkg;
   typedef enum logic [3:0] {
      UCG_ASYNC_NORMAL = 4'h1,
      UCG_ASYNC_DOUBLE = 4'h2,
      UCG_SYNC_MASTER = 4'h4,
      UCG_SYNC_SLAVE = 4'h8
   } ucg_mode_t;
   typedef struct packed {
      logic [8:0] data;
      logic frame_err;
      logic parity_err;
      logic overrun;
   } ucg_rx_word_t;
   typedef struct packed {
      logic sync_mode_select;
      logic double_speed_bit;
      logic transfer_clock_pin_direction;
      logic clock_polarity_select;
      logic [2:0] char_size;
      logic parity_en;
      logic parity_odd;
      logic two_stop;
   } ucg_cfg_t;
endpackage : ucg_pkg

// [hdl/ucg_rx_buf.sv]
// two-entry receive buffer with valid and ready on both sides
// assumes a single clock domain shared with the frame engine
`timescale 1ns/1ps
`default_nettype none
`include "ucg_defs.svh"
module ucg_rx_buf (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire ucg_pkg::ucg_rx_word_t in_word_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output ucg_pkg::ucg_rx_word_t out_word_out
);
   import ucg_pkg::*;
   ucg_rx_word_t mem [0:`UCG_BUF_DEPTH-1];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic do_wr;
   logic do_rd;
   assign in_ready_out = (count != 2'h2);
   assign out_valid_out = (count != 2'h0);
   assign do_wr = ce_in && in_valid_in && in_ready_out;
   assign do_rd = ce_in && out_valid_out && out_ready_in;
   assign out_word_out = mem[rd_ptr];
   always_ff @(posedge clk_in) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_word_in;
      end
   end
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (do_wr) begin
            wr_ptr <= ~wr_ptr;
         end
         if (do_rd) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, do_wr} - {1'b0, do_rd};
      end
   end
   a_buf_no_overfill: assert property (@(posedge clk_in) disable iff (!resetn_in)
      count <= 2'h2) else $error("receive buffer count above depth");
endmodule : ucg_rx_buf
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the serial clock generator and frame engine
// assumes ucg_pkg compiled first and ucg_peer on the far side
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ucg_pkg::*;
   logic clk_in, resetn_in, ce_in, pr, lo_wr, hi_wr, tx_valid, rx_ready;
   logic [7:0] lo;
   logic [3:0] hi;
   logic [8:0] tx_data;
   ucg_cfg_t cfg;
   ucg_rx_word_t rx_word;
   logic tx_ready, rx_valid, tx_done, tx_empty, rx_done, tx_pin, rx_pin, xck_in, xck_out, xck_oe;
   int num_errors, cmp_count;
   ucg_core ucg_core_inst (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .cfg_in(cfg),
      .serial_power_reduction_bit_in(pr), .baud_divisor_low_in(lo), .baud_divisor_low_wr_in(lo_wr),
      .baud_divisor_high_in(hi), .baud_divisor_high_wr_in(hi_wr), .tx_data_in(tx_data),
      .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
      .rx_word_out(rx_word), .tx_complete_out(tx_done), .tx_buffer_empty_out(tx_empty),
      .rx_complete_out(rx_done), .serial_tx_pin_out(tx_pin), .serial_rx_pin_in(rx_pin),
      .transfer_clock_pin_in(xck_in), .transfer_clock_pin_out(xck_out), .transfer_clock_pin_oe_out(xck_oe));
   ucg_peer ucg_peer_inst (.clk_in(clk_in), .tx_line_in(tx_pin), .rx_line_out(rx_pin), .xck_out(xck_in));
   // --------------------------------
   // helpers
   // --------------------------------
   task automatic tick();
      @(posedge clk_in);
      #2;
   endtask : tick
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   function automatic logic [11:0] frm(input logic [8:0] d, input int nb, input logic pen, input logic podd);
      logic [11:0] f;
      logic p;
      f = '1;
      p = podd;
      f[0] = 1'b0;
      for (int i = 0; i < nb; i++) begin
         f[i + 1] = d[i];
         p = p ^ d[i];
      end
      if (pen) f[nb + 1] = p;
      return f;
   endfunction : frm
   task automatic set_div(input logic [11:0] d);
      hi = d[11:8];
      hi_wr = 1'b1;
      tick();
      hi_wr = 1'b0;
      lo = d[7:0];
      lo_wr = 1'b1;
      tick();
      lo_wr = 1'b0;
   endtask : set_div
   task automatic set_mode(input logic s, input logic d, input logic r, input logic [2:0] z, input logic pe,
      input logic po);
      cfg = {s, d, r, 1'b0, z, pe, po, 1'b0};
      tick();
   endtask : set_mode
   task automatic send_tx(input logic [8:0] d);
      int k;
      k = 0;
      while (tx_ready !== 1'b1 && k < 20000) begin
         tick();
         k++;
      end
      tx_data = d;
      tx_valid = 1'b1;
      tick();
      tx_valid = 1'b0;
   endtask : send_tx
   task automatic pop(input logic [8:0] d, input logic fe, input logic pe, input logic ov);
      int k;
      k = 0;
      while (rx_valid !== 1'b1 && k < 2000) begin
         tick();
         k++;
      end
      check({rx_valid, rx_done, 1'b0, rx_word.data}, {2'b11, 1'b0, d});
      check({rx_word.frame_err, rx_word.parity_err, rx_word.overrun}, {fe, pe, ov});
      rx_ready = 1'b1;
      tick();
      rx_ready = 1'b0;
      tick();
   endtask : pop
   // --------------------------------
   // scenarios
   // --------------------------------
   task automatic t_async_tx(input logic dbl, input logic [2:0] z, input int nb, input logic po,
      input logic [8:0] d0, input logic [8:0] d1);
      logic [11:0] f0, f1;
      int cyc, n, k;
      cyc = dbl ? 32 : 64;
      n = nb + 3;
      set_mode(1'b0, dbl, 1'b0, z, 1'b1, po);
      check(xck_oe, 1'b0);
      fork
         begin
            send_tx(d0);
            send_tx(d1);
         end
         begin
            ucg_peer_inst.recv_async(cyc, n, f0);
            ucg_peer_inst.recv_async(cyc, n, f1);
         end
      join
      check(f0, frm(d0, nb, 1'b1, po));
      check(f1, frm(d1, nb, 1'b1, po));
      k = 0;
      while (tx_done !== 1'b1 && k < 200) begin
         tick();
         k++;
      end
      check({tx_done, tx_empty}, 2'b11);
   endtask : t_async_tx
   task automatic t_rx();
      set_mode(1'b0, 1'b0, 1'b0, 3'h3, 1'b1, 1'b0);
      ucg_peer_inst.send_async(64, 11, frm(9'h03C, 8, 1'b1, 1'b0));
      ucg_peer_inst.send_async(64, 11, frm(9'h0C3, 8, 1'b1, 1'b0));
      ucg_peer_inst.send_async(64, 11, frm(9'h05A, 8, 1'b1, 1'b0));
      pop(9'h03C, 1'b0, 1'b0, 1'b0);
      pop(9'h0C3, 1'b0, 1'b0, 1'b0);
      repeat (3) tick();
      check(rx_valid, 1'b0);
      ucg_peer_inst.send_async(64, 11, frm(9'h081, 8, 1'b1, 1'b1));
      pop(9'h081, 1'b0, 1'b1, 1'b1);
      ucg_peer_inst.send_async(64, 11, frm(9'h011, 8, 1'b1, 1'b0) & 12'h3FF);
      pop(9'h011, 1'b1, 1'b0, 1'b0);
   endtask : t_rx
   task automatic t_sync_master();
      int n;
      set_div(12'h102);
      set_mode(1'b1, 1'b0, 1'b1, 3'h3, 1'b0, 1'b0);
      check(xck_oe, 1'b1);
      fork
         send_tx(9'h0A5);
         begin
            n = 0;
            while (xck_out !== 1'b0 && n < 9000) begin tick(); n++; end
            while (xck_out !== 1'b1 && n < 9000) begin tick(); n++; end
            n = 0;
            while (xck_out !== 1'b0 && n < 9000) begin tick(); n++; end
            while (xck_out !== 1'b1 && n < 9000) begin tick(); n++; end
            check(n, 16'd518);
         end
      join
      repeat (5200) tick();
      set_div(12'h003);
      set_mode(1'b0, 1'b0, 1'b1, 3'h3, 1'b0, 1'b0);
      check(xck_oe, 1'b0);
   endtask : t_sync_master
   task automatic t_sync_slave();
      logic [15:0] got;
      int i;
      set_mode(1'b1, 1'b0, 1'b0, 3'h3, 1'b0, 1'b0);
      check(xck_oe, 1'b0);
      send_tx(9'h096);
      ucg_peer_inst.sync_clocks(8, 16, got);
      i = 0;
      while (got[0] !== 1'b0 && i < 6) begin
         got = got >> 1;
         i++;
      end
      check(got[11:0], frm(9'h096, 8, 1'b0, 1'b0));
   endtask : t_sync_slave
   // --------------------------------
   // clock, reset, sequence
   // --------------------------------
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   initial begin
      #(25 * 60000);
      num_errors++;
      end_sim();
   end
   initial begin
      num_errors = 0;
      cmp_count = 0;
      resetn_in = 1'b0;
      ce_in = 1'b1;
      pr = 1'b0;
      {lo_wr, hi_wr, tx_valid, rx_ready} = 4'h0;
      lo = 8'h00;
      hi = 4'h0;
      tx_data = 9'h000;
      cfg = '0;
      repeat (4) @(posedge clk_in);
      #2;
      resetn_in = 1'b1;
      check({tx_pin, xck_oe, rx_valid}, 3'h4);
      pr = 1'b1;
      tick();
      check(tx_ready, 1'b0);
      pr = 1'b0;
      set_div(12'h003);
      t_async_tx(1'b0, 3'h3, 8, 1'b0, 9'h0A5, 9'h03C);
      t_async_tx(1'b1, 3'h2, 7, 1'b1, 9'h055, 9'h00E);
      t_async_tx(1'b0, 3'h7, 9, 1'b1, 9'h1A5, 9'h10F);
      t_rx();
      t_sync_master();
      t_sync_slave();
      end_sim();
   end
endmodule : testbench
`default_nettype wire

// [test/ucg_peer.sv]
// remote serial transceiver: async frames on both lines, slave transfer clock
// assumes the bench calls its tasks just after a rising edge of clk_in
`timescale 1ns/1ps
`default_nettype none
module ucg_peer (
   // clock
   input wire logic clk_in,
   // lines
   input wire logic tx_line_in,
   output logic rx_line_out,
   output logic xck_out
);
   initial begin
      rx_line_out = 1'b1;
      xck_out = 1'b0;
   end
   // --------------------------------
   // async frame, lsb first
   // --------------------------------
   task automatic send_async(input int cyc, input int n, input logic [11:0] f);
      for (int i = 0; i < n; i++) begin
         rx_line_out = f[i];
         repeat (cyc) @(posedge clk_in);
         #2;
      end
      rx_line_out = 1'b1;
   endtask : send_async
   task automatic recv_async(input int cyc, input int n, output logic [11:0] f);
      int k;
      f = '1;
      k = 0;
      while (tx_line_in !== 1'b0 && k < 20000) begin
         @(posedge clk_in);
         #2;
         k++;
      end
      repeat (cyc / 2) @(posedge clk_in);
      #2;
      for (int i = 0; i < n; i++) begin
         f[i] = tx_line_in;
         if (i < n - 1) begin
            repeat (cyc) @(posedge clk_in);
            #2;
         end
      end
   endtask : recv_async
   // --------------------------------
   // slave clock, idle low, sample at fall
   // --------------------------------
   task automatic sync_clocks(input int half, input int n, output logic [15:0] f);
      for (int i = 0; i < n; i++) begin
         xck_out = 1'b1;
         repeat (half) @(posedge clk_in);
         #2;
         f[i] = tx_line_in;
         xck_out = 1'b0;
         repeat (half) @(posedge clk_in);
         #2;
      end
   endtask : sync_clocks
endmodule : ucg_peer
`default_nettype wire
